// [hw/isspi_port.sv]
// spi target port of an inertial sensor, mode 3, 16-bit full duplex frames
`timescale 1ns/1ps
`include "isspi_params.svh"
module isspi_port
  import isspi_pkg::*;
(
  // system side
  input wire logic CLK,
  input wire logic RESET,
  // spi pins, serial clock also clocks the link logic
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic DIN,
  output logic DOUT,
  output logic DOUT_OE,
  // register file side
  output logic REQ_VALID,
  output logic REQ_WRITE,
  output logic [5:0] REQ_ADDR,
  output logic [7:0] REQ_DATA,
  input wire logic [15:0] RD_DATA,
  // mode report
  input wire logic [7:0] SAMPLE_PERIOD_SETTING,
  output logic FAST_MODE,
  output logic [15:0] FRAME_PERIOD_MIN_CYC,
  output logic [15:0] FRAME_GAP_MIN_CYC
);
  function automatic logic [15:0] us_to_cyc(input int us);
    us_to_cyc = 16'(us * `ISSPI_CLK_MHZ);
  endfunction : us_to_cyc

  // leading two frame bits pick the command kind
  function automatic logic is_write_cmd(input logic [15:0] cmd);
    is_write_cmd = cmd[`ISSPI_WR_BIT] & ~cmd[`ISSPI_RSV_BIT];
  endfunction : is_write_cmd

  function automatic logic is_read_cmd(input logic [15:0] cmd);
    is_read_cmd = ~cmd[`ISSPI_WR_BIT] & ~cmd[`ISSPI_RSV_BIT];
  endfunction : is_read_cmd

  // link domain: chip select high acts as async reset of the frame logic
  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic [15:0] rx_q, rx_d;
  logic [14:0] tx_q, tx_d;
  logic [15:0] frame_q, frame_d;
  logic done_tgl_q, done_tgl_d;
  logic [15:0] resp_q;
  logic [4:0] fall_cnt_q, fall_cnt_d;

  always_comb
  begin
    rx_d = {rx_q[14:0], DIN};
    // counter stops at a full frame so extra edges never start another
    bit_cnt_d = bit_cnt_q;
    if (bit_cnt_q != 5'(`ISSPI_FRAME_BITS))
      bit_cnt_d = bit_cnt_q + 5'h01;
    frame_d = frame_q;
    done_tgl_d = done_tgl_q;
    if (!CS_N && bit_cnt_q == 5'(`ISSPI_FRAME_BITS - 1))
    begin
      frame_d = rx_d;
      done_tgl_d = ~done_tgl_q;
    end
  end

  // rising edges only; frame logic held while deselected
  always_ff @(posedge SCLK or posedge CS_N)
  begin
    if (CS_N)
    begin
      bit_cnt_q <= 5'h00;
      rx_q <= 16'h0000;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_d;
      rx_q <= rx_d;
    end
  end

  // frame result survives chip select; cleared only by system reset
  always_ff @(posedge SCLK or posedge RESET)
  begin
    if (RESET)
    begin
      frame_q <= 16'h0000;
      done_tgl_q <= 1'b0;
    end
    else
    begin
      frame_q <= frame_d;
      done_tgl_q <= done_tgl_d;
    end
  end

  // transmit: falling edges shift the next bit out
  always_comb
  begin
    fall_cnt_d = fall_cnt_q;
    if (fall_cnt_q != 5'(`ISSPI_FRAME_BITS))
      fall_cnt_d = fall_cnt_q + 5'h01;
    if (fall_cnt_q == 5'h00)
      tx_d = resp_q[14:0];
    else
      tx_d = {tx_q[13:0], 1'b0};
  end

  always_ff @(negedge SCLK or posedge CS_N)
  begin
    if (CS_N)
    begin
      fall_cnt_q <= 5'h00;
      tx_q <= 15'h0000;
    end
    else
    begin
      fall_cnt_q <= fall_cnt_d;
      tx_q <= tx_d;
    end
  end

  // msb combinationally while no falling edge seen yet
  always_comb
  begin
    DOUT = (fall_cnt_q == 5'h00) ? resp_q[15] : tx_q[14];
    DOUT_OE = ~CS_N;
  end

  // system domain: toggle crossing of completed frame
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
  logic tgl_s1_d, tgl_s2_d, tgl_s3_d;
  logic cs_s1_q, cs_s1_d, cs_s2_q, cs_s2_d;
  logic [15:0] hold_q, hold_d;
  logic hold_pend_q, hold_pend_d;
  logic [15:0] cmd_q, cmd_d;
  isspi_req_t req_q, req_d;
  logic [15:0] resp_d;
  logic rd_pend_q, rd_pend_d;
  isspi_state_t st_q, st_d;

  // chip select is a pin to this domain: two stages before any use
  always_comb
  begin
    tgl_s1_d = done_tgl_q;
    tgl_s2_d = tgl_s1_q;
    tgl_s3_d = tgl_s2_q;
    cs_s1_d = CS_N;
    cs_s2_d = cs_s1_q;
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
    end
    else
    begin
      tgl_s1_q <= tgl_s1_d;
      tgl_s2_q <= tgl_s2_d;
      tgl_s3_q <= tgl_s3_d;
      cs_s1_q <= cs_s1_d;
      cs_s2_q <= cs_s2_d;
    end
  end

  // frame_q is stable long before the toggle is seen two stages late
  always_comb
  begin
    cmd_d = cmd_q;
    req_d = '0;
    resp_d = resp_q;
    rd_pend_d = rd_pend_q;
    hold_d = hold_q;
    hold_pend_d = hold_pend_q;
    st_d = st_q;
    // a frame in flight keeps its response; the new one waits for deselect.
    // limitation: select may fall while it lands, still well before the
    // first clock edge, since the crossing takes only a few cycles
    if (hold_pend_q && cs_s2_q)
    begin
      resp_d = hold_q;
      hold_pend_d = 1'b0;
    end
    case (st_q)
      ISSPI_IDLE:
      begin
        if (tgl_s2_q != tgl_s3_q)
        begin
          cmd_d = frame_q;
          st_d = ISSPI_WAIT;
        end
      end
      ISSPI_WAIT:
      begin
        req_d.valid = 1'b1;
        req_d.write = is_write_cmd(cmd_q);
        req_d.addr = cmd_q[`ISSPI_ADDR_MSB:`ISSPI_ADDR_LSB];
        req_d.data = cmd_q[7:0];
        rd_pend_d = is_read_cmd(cmd_q);
        st_d = ISSPI_LOAD;
      end
      ISSPI_LOAD:
      begin
        // register answers in the same cycle the request is on the port
        if (rd_pend_q)
        begin
          hold_d = RD_DATA;
          hold_pend_d = 1'b1;
        end
        rd_pend_d = 1'b0;
        st_d = ISSPI_IDLE;
      end
      default:
        st_d = ISSPI_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      cmd_q <= 16'h0000;
      req_q <= '0;
      resp_q <= `ISSPI_RESP_RESET;
      rd_pend_q <= 1'b0;
      hold_q <= `ISSPI_RESP_RESET;
      hold_pend_q <= 1'b0;
      st_q <= ISSPI_IDLE;
    end
    else
    begin
      cmd_q <= cmd_d;
      req_q <= req_d;
      resp_q <= resp_d;
      rd_pend_q <= rd_pend_d;
      hold_q <= hold_d;
      hold_pend_q <= hold_pend_d;
      st_q <= st_d;
    end
  end

  assign REQ_VALID = req_q.valid;
  assign REQ_WRITE = req_q.write;
  assign REQ_ADDR = req_q.addr;
  assign REQ_DATA = req_q.data;

  // mode report so the host side knows its own limits
  logic fast_q, fast_d;
  logic [15:0] period_q, period_d, gap_q, gap_d;
  always_comb
  begin
    fast_d = (SAMPLE_PERIOD_SETTING <= `ISSPI_FAST_MAX_SETTING);
    period_d = fast_d ? us_to_cyc(`ISSPI_FRAME_PERIOD_FAST_US)
                      : us_to_cyc(`ISSPI_FRAME_PERIOD_NORM_US);
    gap_d = fast_d ? us_to_cyc(`ISSPI_FRAME_GAP_FAST_US)
                   : us_to_cyc(`ISSPI_FRAME_GAP_NORM_US);
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      fast_q <= 1'b0;
      period_q <= 16'h0000;
      gap_q <= 16'h0000;
    end
    else
    begin
      fast_q <= fast_d;
      period_q <= period_d;
      gap_q <= gap_d;
    end
  end

  assign FAST_MODE = fast_q;
  assign FRAME_PERIOD_MIN_CYC = period_q;
  assign FRAME_GAP_MIN_CYC = gap_q;
endmodule : isspi_port

// [hw/isspi_params.svh]
// timing and field constants for the inertial sensor spi target port
`ifndef ISSPI_PARAMS_SVH
`define ISSPI_PARAMS_SVH
`define ISSPI_FRAME_BITS 16
`define ISSPI_CNT_W 5
`define ISSPI_ADDR_W 6
`define ISSPI_FAST_MAX_SETTING 8'h09
`define ISSPI_WR_BIT 15
`define ISSPI_RSV_BIT 14
`define ISSPI_ADDR_MSB 13
`define ISSPI_ADDR_LSB 8
`define ISSPI_FRAME_PERIOD_FAST_US 40
`define ISSPI_FRAME_PERIOD_NORM_US 160
`define ISSPI_FRAME_GAP_FAST_US 9
`define ISSPI_FRAME_GAP_NORM_US 75
`define ISSPI_CLK_MHZ 125
`define ISSPI_RESP_RESET 16'h0000
`endif

// [hw/isspi_pkg.sv]
// types shared by the inertial sensor spi target port
package isspi_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] addr;
    logic [7:0] data;
  } isspi_req_t;
  typedef enum logic [1:0] {
    ISSPI_IDLE,
    ISSPI_WAIT,
    ISSPI_LOAD
  } isspi_state_t;
endpackage : isspi_pkg

// [verif/isspi_props.sv]
// assertion checker for the spi target port
`timescale 1ns/1ps
module isspi_props (
  input wire logic CLK, RESET, SCLK, CS_N, DIN, DOUT_OE,
  input wire logic REQ_VALID, REQ_WRITE, FAST_MODE,
  input wire logic [5:0] REQ_ADDR,
  input wire logic [7:0] REQ_DATA, SAMPLE_PERIOD_SETTING,
  input wire logic [15:0] FRAME_PERIOD_MIN_CYC, FRAME_GAP_MIN_CYC
);
  logic [15:0] sh_q;
  // frame is long closed when the request shows, so no sync needed
  always_ff @(posedge SCLK)
  begin
    if (!CS_N) sh_q <= {sh_q[14:0], DIN};
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  a_oe_follows_cs: assert property (DOUT_OE == !CS_N)
    else $error("oe");
  a_mode_decode: assert property (!$past(RESET) |-> FAST_MODE
    == ($past(SAMPLE_PERIOD_SETTING) <= 8'h09)) else $error("mode");
  a_period_count: assert property (!$past(RESET) |->
    FRAME_PERIOD_MIN_CYC == (FAST_MODE ? 16'h1388 : 16'h4E20))
    else $error("period");
  a_gap_count: assert property (!$past(RESET) |->
    FRAME_GAP_MIN_CYC == (FAST_MODE ? 16'h0465 : 16'h249F))
    else $error("gap");
  a_req_single: assert property (REQ_VALID |=> !REQ_VALID)
    else $error("pulse");
  a_req_kind: assert property (REQ_VALID |->
    REQ_WRITE == (sh_q[15:14] == 2'h2)) else $error("kind");
  a_req_addr: assert property (REQ_VALID |->
    REQ_ADDR == sh_q[13:8]) else $error("addr");
  a_req_data: assert property (REQ_VALID && REQ_WRITE |->
    REQ_DATA == sh_q[7:0]) else $error("data");
  c_write: cover property (REQ_VALID && REQ_WRITE);
  c_read: cover property (REQ_VALID && !REQ_WRITE);
  c_fast: cover property ($rose(FAST_MODE));
endmodule : isspi_props
bind isspi_port isspi_props chk_u (.CLK(CLK), .RESET(RESET), .SCLK(SCLK),
  .CS_N(CS_N), .DIN(DIN), .DOUT_OE(DOUT_OE), .REQ_VALID(REQ_VALID),
  .REQ_WRITE(REQ_WRITE), .FAST_MODE(FAST_MODE), .REQ_ADDR(REQ_ADDR),
  .REQ_DATA(REQ_DATA), .SAMPLE_PERIOD_SETTING(SAMPLE_PERIOD_SETTING),
  .FRAME_PERIOD_MIN_CYC(FRAME_PERIOD_MIN_CYC),
  .FRAME_GAP_MIN_CYC(FRAME_GAP_MIN_CYC));

// [verif/isspi_host.sv]
// host spi controller model, mode 3, 16-bit frames
`timescale 1ns/1ps
module isspi_host (
  output logic SCLK,
  output logic CS_N,
  output logic DIN,
  input wire logic SDO
);
  // late in time zero so the select edge clears the link logic
  initial {SCLK, CS_N, DIN} <= 3'h7;
  // n below 16 gives a deliberately cut frame
  task automatic xfer(input logic [15:0] tx, input int n,
    output logic [15:0] rx);
    #3.3 CS_N = 0;
    #50 rx[15] = SDO;
    for (int k = 1; k <= n; k++)
    begin
      SCLK = 0;
      DIN = tx[16 - k];
      #7.5 SCLK = 1;
      if (k < 16) rx[15 - k] = SDO;
      #7.5;
    end
    CS_N = 1;
    DIN = ~DIN;
  endtask : xfer
endmodule : isspi_host

// [verif/testbench.sv]
// self-checking bench for the spi target port
`timescale 1ns/1ps
module testbench;
  logic CLK = 0, RESET = 0, DOUT, DOUT_OE, REQ_VALID, REQ_WRITE, f;
  logic SCLK, CS_N, DIN, FAST_MODE;
  logic [5:0] REQ_ADDR, a;
  logic [7:0] REQ_DATA, SAMPLE_PERIOD_SETTING = 8'h00;
  logic [7:0] mt [4] = '{8'h0A, 8'hFF, 8'h00, 8'h09};
  logic [15:0] RD_DATA = 16'h0000, FRAME_PERIOD_MIN_CYC;
  logic [15:0] FRAME_GAP_MIN_CYC, rx, prev = 16'h0000;
  logic [31:0] r = 32'h000168DB;
  int failures = 0, compares = 0;
  wire sdo = DOUT_OE ? DOUT : 1'bz;
  initial forever #4 CLK = ~CLK;
  isspi_port dut_u (.CLK(CLK), .RESET(RESET), .SCLK(SCLK), .CS_N(CS_N),
    .DIN(DIN), .DOUT(DOUT), .DOUT_OE(DOUT_OE), .REQ_VALID(REQ_VALID),
    .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_DATA(REQ_DATA),
    .RD_DATA(RD_DATA), .SAMPLE_PERIOD_SETTING(SAMPLE_PERIOD_SETTING),
    .FAST_MODE(FAST_MODE), .FRAME_PERIOD_MIN_CYC(FRAME_PERIOD_MIN_CYC),
    .FRAME_GAP_MIN_CYC(FRAME_GAP_MIN_CYC));
  isspi_host host_u (.SCLK(SCLK), .CS_N(CS_N), .DIN(DIN), .SDO(sdo));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic frame(input logic [15:0] tx, input int n);
    host_u.xfer(tx, n, rx);
    repeat (12) if (REQ_VALID !== 1'b1) @(negedge CLK);
    chk("valid", n == 16, REQ_VALID);
    if (n == 16)
    begin
      chk("kind", tx[15:14] == 2'h2, REQ_WRITE);
      chk("addr", tx[13:8], REQ_ADDR);
      if (tx[15:14] == 2'h2) chk("data", tx[7:0], REQ_DATA);
    end
    // frame start spacing covers the idle gap too
    #40000;
  endtask : frame
  initial
  begin
    // a real edge at time zero so every asynchronous reset fires
    RESET <= 1;
    repeat (2) @(posedge CLK);
    RESET <= 0;
    repeat (4) @(posedge CLK);
    foreach (mt[i])
    begin
      SAMPLE_PERIOD_SETTING <= mt[i];
      repeat (2) @(posedge CLK);
      @(negedge CLK);
      f = mt[i] <= 8'h09;
      chk("fast", f, FAST_MODE);
      chk("period", f ? 40 * 125 : 160 * 125, FRAME_PERIOD_MIN_CYC);
      chk("gap", f ? 9 * 125 : 75 * 125, FRAME_GAP_MIN_CYC);
      @(posedge CLK);
    end
    $display("mode test done");
    for (int i = 0; i < 3; i++)
    begin
      r = lfsr(r);
      a = i == 0 ? 6'h3F : r[5:0];
      @(posedge CLK);
      RD_DATA <= r[31:16];
      frame({2'h2, a, r[15:8]}, 16);
      chk("resp", prev, rx);
      frame({2'h0, a, r[7:0]}, 16);
      chk("resp", prev, rx);
      frame({i[0], 1'b1, a, 8'h00}, 16);
      chk("resp", r[31:16], rx);
      prev = r[31:16];
      frame(r[15:0], 8);
    end
    $display("frame test done");
    report_and_stop();
  end
  initial
  begin
    #700000;
    failures++;
    report_and_stop();
  end
endmodule : testbench
